// ### logic/srx_cfg.svh
`ifndef SRX_CFG_SVH
`define SRX_CFG_SVH
// register word addresses (byte address = word index * 4)
`define SRX_CS_FIRST      8'h20
`define SRX_CS_LAST       8'h37
`define SRX_IRQ_STAT      8'h1C
`define SRX_IRQ_MASK      8'h1D
`define SRX_BUF_CFG       8'h10
`define SRX_CS_SWITCH     8'h11
`define SRX_UB_ADDR       8'h12
`define SRX_UB_DATA       8'h13
`define SRX_QSUB_FIRST    8'h40
`define SRX_QSUB_LAST     8'h49
`define SRX_QSUB_STAT     8'h4A
// buffer configuration fields
`define SRX_CFG_SIZE_BIT  0
`define SRX_CFG_UPD_LO    1
`define SRX_CFG_MODE_BIT  3
// interrupt status fields
`define SRX_IRQ_UB_BIT    0
`define SRX_IRQ_CS_BIT    1
// sizes and counts
`define SRX_CS_BYTES      24
`define SRX_CS_BITS       192
`define SRX_UB_SMALL      48
`define SRX_UB_LARGE      96
`define SRX_CMP_BYTES     5
`define SRX_IU_ZERO_LIM   8
`define SRX_QSUB_IUS      96
`define SRX_CRC_POLY      16'h1021
`define SRX_CFG_RESET     8'h00
`endif

// ### logic/srx_pkg.sv
package srx_pkg;
   typedef enum logic [1:0] {
      SRX_UB_OFF  = 2'h0,
      SRX_UB_RAW  = 2'h1,
      SRX_UB_AUTO = 2'h2,
      SRX_UB_RSV  = 2'h3
   } srx_ubcfg_t;
   typedef enum logic [2:0] {
      SRX_IU_IDLE = 3'b001,
      SRX_IU_BITS = 3'b010,
      SRX_IU_GAP  = 3'b100
   } srx_iu_state_t;
endpackage

// ### logic/srx_rx_buffers.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
// Function
// RL1: each channel status block kept as 24 bytes
// RL2: status bytes at word addresses 0x20..0x37
// RL3: first-stage buffer fills from stream always
// RL4: copy to visible buffer after full block
// RL5: 384 bits kept, select picks channel
// RL6: user bits read via indirect address/data pair
// RL7: user data read advances indirect address
// RL8: host sets address zero, reads repeatedly
// RL9: status flag per block or on change
// RL10: user buffer 384 or 768 bits, Z aligned
// RL11: config 00 ignores, 01 copies when full
// RL12: config 10 follows pro byte or units
// RL13: auto pro nibble zero ignores, user-defined raw
// RL14: user buffer full sets masked flag
// RL15: zero stuffing dropped, units stored only
// RL16: over eight zeros ends message, copy, restart; the code ends the message on the eighth zero
// RL17: unit byte is 1 then Q..W bits
// RL18: 96 units give 10-byte Q subcode
// RL19: last 16 Q bits checked as CRC
// RL20: CRC error sticky until read
// RL21: interrupt status cleared by its read
// RL22: CRC-16 x16+x12+x5+1, check field inverted
`include "srx_cfg.svh"
module srx_rx_buffers
   import srx_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // decoded receiver stream
   input  wire logic        bit_valid_i,
   input  wire logic        sub_b_i,
   input  wire logic        blk_start_i,
   input  wire logic        cs_bit_i,
   input  wire logic        user_bit_i,
   // status
   output logic             status_block_flag_o,
   output logic             user_buffer_full_flag_o
);
   // first-stage and visible status buffers, one bit row per channel
   logic [`SRX_CS_BITS-1:0] cs_stage_a_r, cs_stage_b_r, cs_vis_a_r, cs_vis_b_r;
   logic [7:0]  cs_idx_r;
   logic        cs_a_done_r, cs_b_done_r, cs_any_r;
   logic [7:0]  buf_cfg_r;
   logic        status_channel_select_r;
   logic [1:0]  irq_mask_r;
   logic [1:0]  irq_stat_r;
   logic        subcode_check_error_r;
   logic [6:0]  ub_addr_r;
   logic [7:0]  ub_stage_r [0:`SRX_UB_LARGE-1];
   logic [7:0]  ub_vis_r   [0:`SRX_UB_LARGE-1];
   logic [6:0]  ub_wptr_r;
   logic [2:0]  ub_bit_r;
   logic [7:0]  ub_shift_r;
   logic        ub_sync_r;
   logic        ub_copy_r;
   srx_iu_state_t iu_st_r;
   logic [3:0]  iu_zero_r;
   logic [95:0] q_bits_r;
   logic [79:0] q_data_r;
   logic [6:0]  q_cnt_r;
   logic        q_done_r;
   logic        ack_r;
   logic [31:0] rdat_r;

   wire logic       user_buffer_size_sel = buf_cfg_r[`SRX_CFG_SIZE_BIT];
   wire logic [1:0] user_buffer_update_cfg = buf_cfg_r[`SRX_CFG_UPD_LO+1:`SRX_CFG_UPD_LO];
   wire logic       status_flag_mode = buf_cfg_r[`SRX_CFG_MODE_BIT];
   wire logic [7:0] word_idx = adr_i[9:2];
   wire logic       req = cyc_i & stb_i & ~ack_r;
   wire logic       rd_req = req & ~we_i;
   wire logic       wr_req = req & we_i & sel_i[0];
   wire logic       pro_a = cs_vis_a_r[0];
   wire logic [3:0] pro_nib = cs_vis_a_r[15:12];

   // effective user bit handling: 0 off, 1 raw, 2 units
   function automatic logic [1:0] eff_mode(input logic [1:0] cfg, input logic pro,
                                           input logic [3:0] nib);
      logic [1:0] m;
      m = 2'd0;
      if (cfg == SRX_UB_RAW) begin
         m = 2'd1;
      end else if (cfg == SRX_UB_AUTO) begin
         // RL12 RL13 auto pro nibble
         if (!pro) begin
            m = 2'd2;
         end else if (nib == 4'h0) begin
            m = 2'd0;
         end else begin
            m = 2'd1;
         end
      end
      return m;
   endfunction

   // CRC-16 over the 80 data bits, msb first
   function automatic logic [15:0] crc80(input logic [79:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 79; i >= 0; i--) begin
         c = (c[15] ^ d[i]) ? ((c << 1) ^ `SRX_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   wire logic [1:0] ub_mode = eff_mode(user_buffer_update_cfg, pro_a, pro_nib);
   wire logic [6:0] ub_len  = user_buffer_size_sel ? 7'(`SRX_UB_LARGE) : 7'(`SRX_UB_SMALL);

   // RL1 RL3 stage holds 192 bits per channel, fills always
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_stage_a_r <= '0;
         cs_stage_b_r <= '0;
         cs_idx_r     <= 8'h00;
         cs_a_done_r  <= 1'b0;
         cs_b_done_r  <= 1'b0;
      end else begin
         cs_a_done_r <= 1'b0;
         cs_b_done_r <= 1'b0;
         if (bit_valid_i) begin
            if (!sub_b_i) begin
               cs_stage_a_r[blk_start_i ? 8'h00 : cs_idx_r] <= cs_bit_i;
            end else begin
               cs_stage_b_r[cs_idx_r] <= cs_bit_i;
               cs_b_done_r <= (cs_idx_r == 8'(`SRX_CS_BITS-1));
               cs_idx_r <= (cs_idx_r == 8'(`SRX_CS_BITS-1)) ? 8'h00 : cs_idx_r + 8'h01;
            end
            if (!sub_b_i && blk_start_i) begin
               cs_idx_r <= 8'h00;
            end
         end
      end
   end

   // RL4 copy after both channels complete
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_vis_a_r <= '0;
         cs_vis_b_r <= '0;
         cs_any_r   <= 1'b0;
      end else if (cs_b_done_r) begin
         cs_vis_a_r <= cs_stage_a_r;
         cs_vis_b_r <= cs_stage_b_r;
         cs_any_r   <= 1'b1;
      end
   end

   // RL9 flag per block or on first-bytes change
   wire logic cs_changed = (cs_stage_a_r[`SRX_CMP_BYTES*8-1:0] != cs_vis_a_r[`SRX_CMP_BYTES*8-1:0])
                         | (cs_stage_b_r[`SRX_CMP_BYTES*8-1:0] != cs_vis_b_r[`SRX_CMP_BYTES*8-1:0])
                         | ~cs_any_r;
   wire logic cs_event = cs_b_done_r & (~status_flag_mode | cs_changed);

   // user bits: raw bytes or information units
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ub_wptr_r  <= 7'h00;
         ub_bit_r   <= 3'h0;
         ub_shift_r <= 8'h00;
         ub_sync_r  <= 1'b0;
         ub_copy_r  <= 1'b0;
         iu_st_r    <= SRX_IU_IDLE;
         iu_zero_r  <= 4'h0;
      end else begin
         ub_copy_r <= 1'b0;
         // RL11 mode off ignores bits
         // RL10 raw block takes both subframes, 384 bits per block
         if (bit_valid_i && ub_mode == 2'd1) begin
            // RL10 raw block starts at Z
            if (blk_start_i || ub_sync_r) begin
               ub_sync_r  <= 1'b1;
               ub_shift_r <= {ub_shift_r[6:0], user_bit_i};
               ub_bit_r   <= ub_bit_r + 3'h1;
               if (blk_start_i && !ub_sync_r) begin
                  ub_wptr_r  <= 7'h00;
                  ub_bit_r   <= 3'h1;
                  ub_shift_r <= {7'h00, user_bit_i};
               end else if (ub_bit_r == 3'h7) begin
                  ub_stage_r[ub_wptr_r] <= {ub_shift_r[6:0], user_bit_i};
                  // RL11 copy when first buffer full
                  if (ub_wptr_r == ub_len - 7'h01) begin
                     ub_wptr_r <= 7'h00;
                     ub_copy_r <= 1'b1;
                     ub_sync_r <= 1'b0;
                  end else begin
                     ub_wptr_r <= ub_wptr_r + 7'h01;
                  end
               end
            end
         end else if (bit_valid_i && !sub_b_i && ub_mode == 2'd2) begin
            ub_sync_r <= 1'b0;
            case (iu_st_r)
               SRX_IU_IDLE, SRX_IU_GAP: begin
                  // RL15 stuffing zeros dropped
                  if (user_bit_i) begin
                     iu_st_r    <= SRX_IU_BITS;
                     ub_bit_r   <= 3'h0;
                     ub_shift_r <= 8'h01;
                     iu_zero_r  <= 4'h0;
                  end else if (iu_st_r == SRX_IU_GAP) begin
                     iu_zero_r <= (iu_zero_r == 4'hF) ? 4'hF : iu_zero_r + 4'h1;
                     // RL16 long gap ends message
                     if (iu_zero_r == 4'(`SRX_IU_ZERO_LIM)) begin
                        iu_st_r   <= SRX_IU_IDLE;
                        ub_copy_r <= (ub_wptr_r != 7'h00);
                        ub_wptr_r <= 7'h00;
                     end
                  end
               end
               SRX_IU_BITS: begin
                  // RL17 leading one then Q..W
                  ub_shift_r <= {ub_shift_r[6:0], user_bit_i};
                  ub_bit_r   <= ub_bit_r + 3'h1;
                  if (ub_bit_r == 3'h6) begin
                     ub_stage_r[ub_wptr_r] <= {ub_shift_r[6:0], user_bit_i};
                     ub_wptr_r <= (ub_wptr_r == ub_len - 7'h01) ? ub_wptr_r : ub_wptr_r + 7'h01;
                     iu_st_r   <= SRX_IU_GAP;
                     iu_zero_r <= 4'h1;
                  end
               end
               default: iu_st_r <= SRX_IU_IDLE;
            endcase
         end else if (ub_mode == 2'd0) begin
            ub_sync_r <= 1'b0;
            iu_st_r   <= SRX_IU_IDLE;
         end
      end
   end

   // second user buffer copy
   always_ff @(posedge clk_i) begin
      if (ub_copy_r) begin
         for (int i = 0; i < `SRX_UB_LARGE; i++) begin
            ub_vis_r[i] <= ub_stage_r[i];
         end
      end
   end

   // RL18 gather Q bits from 96 units
   wire logic iu_store = bit_valid_i & ~sub_b_i & (ub_mode == 2'd2)
                       & (iu_st_r == SRX_IU_BITS) & (ub_bit_r == 3'h6);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_bits_r <= '0;
         q_data_r <= '0;
         q_cnt_r  <= 7'h00;
         q_done_r <= 1'b0;
      end else begin
         q_done_r <= 1'b0;
         if (iu_store) begin
            q_bits_r <= {q_bits_r[94:0], ub_shift_r[5]};
            if (q_cnt_r == 7'(`SRX_QSUB_IUS-1)) begin
               q_cnt_r  <= 7'h00;
               q_done_r <= 1'b1;
            end else begin
               q_cnt_r <= q_cnt_r + 7'h01;
            end
         end
         if (q_done_r) begin
            q_data_r <= q_bits_r[95:16];
         end
      end
   end

   // RL19 RL22 inverted check field compared
   wire logic q_bad = q_done_r & (crc80(q_bits_r[95:16]) != ~q_bits_r[15:0]);
   wire logic rd_qstat = rd_req & (word_idx == `SRX_QSUB_STAT);
   wire logic rd_irq   = rd_req & (word_idx == `SRX_IRQ_STAT);

   // RL20 sticky, set wins over read clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         subcode_check_error_r <= 1'b0;
      end else begin
         subcode_check_error_r <= q_bad | (subcode_check_error_r & ~rd_qstat);
      end
   end

   // RL14 RL21 sticky flags cleared by read, only the user flag masked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= 2'h0;
      end else begin
         irq_stat_r[`SRX_IRQ_UB_BIT] <= (ub_copy_r & irq_mask_r[`SRX_IRQ_UB_BIT])
                                     | (irq_stat_r[`SRX_IRQ_UB_BIT] & ~rd_irq);
         irq_stat_r[`SRX_IRQ_CS_BIT] <= cs_event
                                     | (irq_stat_r[`SRX_IRQ_CS_BIT] & ~rd_irq);
      end
   end

   // control registers and indirect address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_cfg_r               <= `SRX_CFG_RESET;
         status_channel_select_r <= 1'b0;
         irq_mask_r              <= 2'h0;
         ub_addr_r               <= 7'h00;
      end else begin
         if (wr_req && word_idx == `SRX_BUF_CFG) begin
            buf_cfg_r <= {4'h0, dat_i[3:0]};
         end
         if (wr_req && word_idx == `SRX_CS_SWITCH) begin
            status_channel_select_r <= dat_i[0];
         end
         if (wr_req && word_idx == `SRX_IRQ_MASK) begin
            irq_mask_r <= dat_i[1:0];
         end
         // RL6 host sets offset
         if (wr_req && word_idx == `SRX_UB_ADDR) begin
            ub_addr_r <= dat_i[6:0];
         // RL7 advance on data read
         end else if (rd_req && word_idx == `SRX_UB_DATA) begin
            ub_addr_r <= (ub_addr_r == ub_len - 7'h01) ? 7'h00 : ub_addr_r + 7'h01;
         end
      end
   end

   // read mux
   logic [31:0] rd_mux;
   logic [7:0]  cs_off;
   always_comb begin
      rd_mux = 32'h0000_0000;
      cs_off = word_idx - `SRX_CS_FIRST;
      // RL2 RL5 status window, selected channel
      if (word_idx >= `SRX_CS_FIRST && word_idx <= `SRX_CS_LAST) begin
         rd_mux[7:0] = status_channel_select_r ? cs_vis_b_r[cs_off*8 +: 8]
                                               : cs_vis_a_r[cs_off*8 +: 8];
      end else if (word_idx >= `SRX_QSUB_FIRST && word_idx <= `SRX_QSUB_LAST) begin
         rd_mux[7:0] = q_data_r[79 - (word_idx - `SRX_QSUB_FIRST)*8 -: 8];
      end else begin
         case (word_idx)
            `SRX_BUF_CFG:    rd_mux[7:0] = buf_cfg_r;
            `SRX_CS_SWITCH:  rd_mux[0] = status_channel_select_r;
            `SRX_IRQ_MASK:   rd_mux[1:0] = irq_mask_r;
            `SRX_IRQ_STAT:   rd_mux[1:0] = irq_stat_r;
            `SRX_UB_ADDR:    rd_mux[6:0] = ub_addr_r;
            `SRX_UB_DATA:    rd_mux[7:0] = ub_vis_r[ub_addr_r];
            `SRX_QSUB_STAT:  rd_mux[0] = subcode_check_error_r;
            default:         rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // one-cycle ack, registered data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r  <= req;
         rdat_r <= rd_req ? rd_mux : 32'h0000_0000;
      end
   end

   // status flag outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_block_flag_o     <= 1'b0;
         user_buffer_full_flag_o <= 1'b0;
      end else begin
         status_block_flag_o     <= irq_stat_r[`SRX_IRQ_CS_BIT];
         user_buffer_full_flag_o <= irq_stat_r[`SRX_IRQ_UB_BIT];
      end
   end

   assign ack_o = ack_r;
   assign dat_o = rdat_r;
endmodule // srx_rx_buffers

// ### test/srx_rx_buffers_asserts.sv
`timescale 1ns/10ps
`include "srx_cfg.svh"
module srx_rx_buffers_asserts (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // bus
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   // stream and flags
   input  wire logic        bit_valid_i,
   input  wire logic        status_block_flag_o,
   input  wire logic        user_buffer_full_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_irq;
   assign rd_irq = cyc_i && stb_i && !we_i && !ack_o && adr_i[9:2] == `SRX_IRQ_STAT;
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   sequence s_irq_rd; rd_irq ##1 !bit_valid_i; endsequence
   property p_answer; s_take |=> ack_o; endproperty
   a_answer: assert property (p_answer) else $error("no ack after request");
   property p_pulse; ack_o |=> !ack_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   property p_idle_zero; !ack_o |-> dat_o == 32'h0; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data without ack");
   property p_cs_lane;
      ack_o && !we_i && adr_i[9:2] inside {[8'h20:8'h37]} |-> dat_o[31:8] == 24'h0;
   endproperty
   a_cs_lane: assert property (p_cs_lane) else $error("status byte outside low lane");
   property p_unmapped;
      ack_o && !we_i && adr_i[9:2] inside {[8'h38:8'h3F]} |-> dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("status buffer too long");
   property p_irq_clr;
      s_irq_rd |-> ##[1:4] (!user_buffer_full_flag_o && !status_block_flag_o);
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("flags kept after status read");
   property p_cs_rise;
      $rose(status_block_flag_o) |-> $past(bit_valid_i, 1) || $past(bit_valid_i, 2)
         || $past(bit_valid_i, 3);
   endproperty
   a_cs_rise: assert property (p_cs_rise) else $error("status flag without stream");
   property p_ub_rise;
      $rose(user_buffer_full_flag_o) |-> $past(bit_valid_i, 1) || $past(bit_valid_i, 2)
         || $past(bit_valid_i, 3);
   endproperty
   a_ub_rise: assert property (p_ub_rise) else $error("user flag without stream");
   property p_cs_hold;
      $fell(status_block_flag_o) |-> $past(rd_irq, 1) || $past(rd_irq, 2) || $past(rd_irq, 3)
         || $past(rd_irq, 4) || $past(rd_irq, 5);
   endproperty
   a_cs_hold: assert property (p_cs_hold) else $error("status flag fell unread");
   property p_ub_hold;
      $fell(user_buffer_full_flag_o) |-> $past(rd_irq, 1) || $past(rd_irq, 2)
         || $past(rd_irq, 3) || $past(rd_irq, 4);
   endproperty
   a_ub_hold: assert property (p_ub_hold) else $error("user flag fell unread");
endmodule // srx_rx_buffers_asserts
bind srx_rx_buffers srx_rx_buffers_asserts srx_rx_buffers_asserts_inst (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .bit_valid_i(bit_valid_i),
   .status_block_flag_o(status_block_flag_o),
   .user_buffer_full_flag_o(user_buffer_full_flag_o));

// ### test/srx_src_model.sv
`timescale 1ns/10ps
module srx_src_model (
   // clock
   input  wire logic clk_i,
   // decoded stream
   output logic      bit_valid_o,
   output logic      sub_b_o,
   output logic      blk_start_o,
   output logic      cs_bit_o,
   output logic      user_bit_o
);
   initial begin
      bit_valid_o = 1'b0;
      sub_b_o = 1'b0;
      blk_start_o = 1'b0;
      cs_bit_o = 1'b0;
      user_bit_o = 1'b0;
   end
   // status byte k is k^ax on A, k^bx on B; user byte j is j^ux, first bit msb
   task automatic send_block(input logic [7:0] ax, input logic [7:0] bx, input logic [7:0] ux);
      int n;
      logic [7:0] cb;
      logic [7:0] ub;
      for (n = 0; n < 384; n++) begin
         cb = 8'(n >> 4) ^ (n[0] ? bx : ax);
         ub = 8'(n >> 3) ^ ux;
         @(posedge clk_i);
         bit_valid_o <= 1'b1;
         sub_b_o <= n[0];
         blk_start_o <= (n == 0);
         cs_bit_o <= cb[(n >> 1) & 7];
         user_bit_o <= ub[7 - (n & 7)];
         @(posedge clk_i);
         // idle slot flips the data so a stale bit never passes for a fresh one
         bit_valid_o <= 1'b0;
         cs_bit_o <= ~cs_bit_o;
         user_bit_o <= ~user_bit_o;
      end
   endtask
endmodule // srx_src_model

// ### test/tb_top.sv
`timescale 1ns/10ps
`include "srx_cfg.svh"
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [9:0]  adr_i = 10'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic        ack_o, bv, sb, bs, cb, ub, sflag, uflag;
   int          failures = 0;
   int          compares = 0;
   int          k;
   always #12.5 clk_i = ~clk_i;
   srx_src_model srx_src_model_inst (.clk_i(clk_i), .bit_valid_o(bv), .sub_b_o(sb),
      .blk_start_o(bs), .cs_bit_o(cb), .user_bit_o(ub));
   srx_rx_buffers srx_rx_buffers_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .bit_valid_i(bv), .sub_b_i(sb), .blk_start_i(bs),
      .cs_bit_i(cb), .user_bit_i(ub), .status_block_flag_o(sflag),
      .user_buffer_full_flag_o(uflag));
   task automatic summarize;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one classic cycle; enters right after an edge, leaves one idle cycle
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      sel_i <= 4'hF;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         failures++;
         summarize();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      check(rd, exp);
   endtask
   task automatic blk(input logic [7:0] ax, input logic [7:0] bx, input logic [7:0] ux);
      srx_src_model_inst.send_block(ax, bx, ux);
      repeat (4) @(posedge clk_i);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b1, `SRX_BUF_CFG, 8'h02);
      bus(1'b1, `SRX_IRQ_MASK, 8'h01);
      blk(8'h5A, 8'hC3, 8'h00);
      check(sflag, 32'h1);
      check(uflag, 32'h1);
      for (k = 0; k < 24; k++) rchk(8'(`SRX_CS_FIRST + k), 32'(k ^ 8'h5A));
      rchk(8'h38, 32'h0);
      bus(1'b1, `SRX_CS_SWITCH, 8'h01);
      for (k = 0; k < 24; k++) rchk(8'(`SRX_CS_FIRST + k), 32'(k ^ 8'hC3));
      rchk(`SRX_IRQ_STAT, 32'h3);
      rchk(`SRX_IRQ_STAT, 32'h0);
      check(sflag, 32'h0);
      bus(1'b1, `SRX_UB_ADDR, 8'h00);
      for (k = 0; k < 48; k++) rchk(`SRX_UB_DATA, 32'(k));
      rchk(`SRX_UB_DATA, 32'h0);
      bus(1'b1, `SRX_UB_ADDR, 8'h05);
      rchk(`SRX_UB_DATA, 32'h5);
      // flag on change only, user bits ignored
      bus(1'b1, `SRX_BUF_CFG, 8'h08);
      blk(8'h5A, 8'hC3, 8'hFF);
      check(sflag, 32'h0);
      rchk(`SRX_IRQ_STAT, 32'h0);
      bus(1'b1, `SRX_UB_ADDR, 8'h00);
      rchk(`SRX_UB_DATA, 32'h0);
      blk(8'hA5, 8'hC3, 8'hFF);
      check(sflag, 32'h1);
      rchk(`SRX_IRQ_STAT, 32'h2);
      bus(1'b1, `SRX_CS_SWITCH, 8'h00);
      rchk(8'h37, 32'(23 ^ 8'hA5));
      // large buffer needs two blocks before it is handed over
      bus(1'b1, `SRX_BUF_CFG, 8'h03);
      blk(8'hA5, 8'hC3, 8'h11);
      check(uflag, 32'h0);
      blk(8'hA5, 8'hC3, 8'h11);
      check(uflag, 32'h1);
      bus(1'b1, `SRX_UB_ADDR, 8'h00);
      for (k = 0; k < 96; k++) rchk(`SRX_UB_DATA, 32'((k % 48) ^ 8'h11));
      rchk(`SRX_IRQ_STAT, 32'h3);
      summarize();
   end
endmodule // tb_top
